// [src/tds_sequencer.sv]
`timescale 1ns/1ps
`include "tds_cfg.svh"
// Operation
// [R1] Delay zero to 3600 s, 1 us steps.
// [R2] Wait delay before every reading per trigger.
// [R3] Minimum loads zero, maximum loads 3600 s.
// [R4] Unset delay uses default from measurement settings.
// [R5] Default follows function and range changes.
// [R6] Explicit delay kept until overwrite, reset, default.
// [R7] DC: 1.5 ms long, 1.0 ms short integration.
// [R8] Ohms: range and integration pick the delay.
// [R9] AC delay set by filter bandwidth.
// [R10] Frequency and period default one second.
// [R11] Delay query: present, min 1 us, max.
// [R12] Sample count held, one to fifty thousand.
// [R13] Sample minimum one, maximum fifty thousand.
// [R14] Sample query: present, min one, max.
// [R15] After final trigger's readings return to idle.
// [R16] Count triggers, idle after trigger count served.
// [R17] Triggers accepted only in wait-for-trigger.
// [R18] Triggers ignored during 20 ms setup.
// [R19] External trigger on falling edge.
// [R20] Microsecond prescaler, delay reloaded per reading.
module tds_sequencer #(
  parameter int unsigned SETUP_CYC = `TDS_SETUP_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_ext_trig_n,
  input  wire logic [7:0]  i_ttl_trig_n,
  input  wire logic        i_sample_done,
  output logic             o_sample_start,
  output logic             o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0]  TICK_LAST  = 4'(`TDS_TICK_CYC - 1);
  localparam logic [31:0] SETUP_LAST = 32'(SETUP_CYC - 1);

  function automatic logic [31:0] tds_default_delay(input tds_pkg::tds_meas_cfg_s c);
    logic [31:0] d;
    d = `TDS_DLY_1S;
    unique case (c.func)
      tds_pkg::TDS_DCV, tds_pkg::TDS_DCI:
        d = c.nplc_ge1 ? `TDS_DLY_1MS5 : `TDS_DLY_1MS; // R7
      tds_pkg::TDS_OHM2, tds_pkg::TDS_OHM4: begin
        if (c.range > `TDS_RNG_1MOHM) d = `TDS_DLY_100MS; // R8
        else if (c.nplc_ge1) d = `TDS_DLY_1MS5;
        else if (c.range == `TDS_RNG_1MOHM) d = `TDS_DLY_10MS;
        else d = `TDS_DLY_1MS;
      end
      tds_pkg::TDS_ACV, tds_pkg::TDS_ACI:
        d = (c.filter == 2'h0) ? `TDS_DLY_7S :
            (c.filter == 2'h1) ? `TDS_DLY_1S : `TDS_DLY_600MS; // R9
      tds_pkg::TDS_FREQ, tds_pkg::TDS_PER: d = `TDS_DLY_1S; // R10
    endcase
    return d;
  endfunction : tds_default_delay

  function automatic logic [15:0] tds_clamp_cnt(input logic [31:0] v);
    if (v == 32'h0) return `TDS_CNT_MIN;
    if (v > 32'(`TDS_CNT_MAX)) return `TDS_CNT_MAX;
    return v[15:0];
  endfunction : tds_clamp_cnt

  ////////////////////////////////////////////////////////////////////////////
  logic                  ack_r;
  logic                  wr_go;
  logic [31:0]           ctl;
  tds_pkg::tds_meas_cfg_s cfg_r;
  logic [31:0]           delay_r;
  logic                  explicit_r;
  logic [15:0]           samp_r;
  logic [15:0]           trigs_r;
  logic [31:0]           active_dly;
  tds_pkg::tds_state_e   st_r;
  logic [31:0]           cnt_r;
  logic [3:0]            pre_r;
  logic [15:0]           samp_left_r;
  logic [15:0]           trig_left_r;
  logic                  ext_prev_r;
  logic                  ttl_prev_r;
  logic                  ttl_now;
  logic                  trig_ev;
  logic                  tick;

  // One wait cycle per access; a write acts at the edge with waitrequest low, read data is registered at the edge before it.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_go = i_avs_write & ack_r;
  assign ctl   = (wr_go && i_avs_address == `TDS_OFF_CTRL) ? i_avs_writedata : 32'h0;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) ack_r <= 1'b0;
    else ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        `TDS_OFF_STATUS:  o_avs_readdata <= {28'h0, explicit_r, st_r};
        `TDS_OFF_DELAY:   o_avs_readdata <= active_dly; // R11
        `TDS_OFF_SAMPLES: o_avs_readdata <= {16'h0, samp_r}; // R14
        `TDS_OFF_TRIGS:   o_avs_readdata <= {16'h0, trigs_r};
        `TDS_OFF_MEASCFG: o_avs_readdata <= {18'h0, cfg_r};
        `TDS_OFF_DLY_MIN: o_avs_readdata <= `TDS_DLY_QMIN_US; // R11
        `TDS_OFF_DLY_MAX: o_avs_readdata <= `TDS_DLY_MAX_US; // R11
        `TDS_OFF_CNT_MIN: o_avs_readdata <= {16'h0, `TDS_CNT_MIN}; // R14
        `TDS_OFF_CNT_MAX: o_avs_readdata <= {16'h0, `TDS_CNT_MAX}; // R14
        default:          o_avs_readdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) cfg_r <= '0;
    else if (wr_go && i_avs_address == `TDS_OFF_MEASCFG)
      cfg_r <= tds_pkg::tds_meas_cfg_s'({2'h0, i_avs_writedata[11:0]});
  end

  // Default is recomputed combinationally, so it tracks every setting change.
  assign active_dly = explicit_r ? delay_r : tds_default_delay(cfg_r); // R4 R5

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      delay_r    <= 32'h0;
      explicit_r <= 1'b0; // R6
    end else if (ctl[`TDS_CTRL_DLYMIN]) begin
      delay_r    <= 32'h0; // R3
      explicit_r <= 1'b1;
    end else if (ctl[`TDS_CTRL_DLYMAX]) begin
      delay_r    <= `TDS_DLY_MAX_US; // R3
      explicit_r <= 1'b1;
    end else if (ctl[`TDS_CTRL_DFLT]) begin
      explicit_r <= 1'b0; // R6
    end else if (wr_go && i_avs_address == `TDS_OFF_DELAY) begin
      delay_r    <= (i_avs_writedata > `TDS_DLY_MAX_US) ? `TDS_DLY_MAX_US
                                                        : i_avs_writedata; // R1
      explicit_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) samp_r <= `TDS_CNT_MIN;
    else if (ctl[`TDS_CTRL_SMPMIN]) samp_r <= `TDS_CNT_MIN; // R13
    else if (ctl[`TDS_CTRL_SMPMAX]) samp_r <= `TDS_CNT_MAX; // R13
    else if (wr_go && i_avs_address == `TDS_OFF_SAMPLES)
      samp_r <= tds_clamp_cnt(i_avs_writedata); // R12
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) trigs_r <= `TDS_CNT_MIN;
    else if (ctl[`TDS_CTRL_TRGMIN] || ctl[`TDS_CTRL_DFLT]) trigs_r <= `TDS_CNT_MIN;
    else if (ctl[`TDS_CTRL_TRGMAX]) trigs_r <= `TDS_CNT_MAX;
    else if (wr_go && i_avs_address == `TDS_OFF_TRIGS)
      trigs_r <= tds_clamp_cnt(i_avs_writedata); // R16
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_prev_r <= 1'b1;
      ttl_prev_r <= 1'b1;
    end else begin
      ext_prev_r <= i_ext_trig_n;
      ttl_prev_r <= ttl_now;
    end
  end

  assign ttl_now = i_ttl_trig_n[cfg_r.ttl_sel];

  always_comb begin
    unique case (cfg_r.src)
      tds_pkg::TDS_SRC_BUS: trig_ev = ctl[`TDS_CTRL_BUSTRG];
      tds_pkg::TDS_SRC_TTL: trig_ev = ttl_prev_r & ~ttl_now;
      tds_pkg::TDS_SRC_EXT: trig_ev = ext_prev_r & ~i_ext_trig_n; // R19
      tds_pkg::TDS_SRC_IMM: trig_ev = 1'b1;
    endcase
  end

  assign tick = (pre_r == TICK_LAST);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) pre_r <= 4'h0;
    else if (st_r != tds_pkg::TDS_DELAY || tick) pre_r <= 4'h0; // R20
    else pre_r <= pre_r + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r           <= tds_pkg::TDS_IDLE;
      cnt_r          <= 32'h0;
      samp_left_r    <= 16'h0;
      trig_left_r    <= 16'h0;
      o_sample_start <= 1'b0;
    end else begin
      o_sample_start <= 1'b0;
      if (ctl[`TDS_CTRL_ABORT]) begin
        st_r <= tds_pkg::TDS_IDLE;
      end else begin
        unique case (st_r)
          tds_pkg::TDS_IDLE: if (ctl[`TDS_CTRL_INIT]) begin // R17
            st_r        <= tds_pkg::TDS_SETUP;
            cnt_r       <= SETUP_LAST;
            trig_left_r <= trigs_r; // R16
          end
          tds_pkg::TDS_SETUP: begin
            if (cnt_r == 32'h0) st_r <= tds_pkg::TDS_WAIT; // R18
            else cnt_r <= cnt_r - 32'h1;
          end
          tds_pkg::TDS_WAIT: if (trig_ev) begin // R17
            st_r        <= tds_pkg::TDS_DELAY;
            cnt_r       <= active_dly; // R2
            samp_left_r <= samp_r;
          end
          tds_pkg::TDS_DELAY: begin
            if (cnt_r == 32'h0) begin
              st_r           <= tds_pkg::TDS_MEAS;
              o_sample_start <= 1'b1;
            end else if (tick) begin
              cnt_r <= cnt_r - 32'h1; // R20
            end
          end
          tds_pkg::TDS_MEAS: if (i_sample_done) begin
            if (samp_left_r > 16'h1) begin
              samp_left_r <= samp_left_r - 16'h1;
              cnt_r       <= active_dly; // R2 R20
              st_r        <= tds_pkg::TDS_DELAY;
            end else if (trig_left_r > 16'h1) begin
              trig_left_r <= trig_left_r - 16'h1; // R16
              st_r        <= tds_pkg::TDS_WAIT;
            end else begin
              st_r <= tds_pkg::TDS_IDLE; // R15
            end
          end
          default: st_r <= tds_pkg::TDS_IDLE;
        endcase
      end
    end
  end

  assign o_busy = (st_r != tds_pkg::TDS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  dly_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R1
    active_dly <= `TDS_DLY_MAX_US) else $error("delay above limit");
  dly_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R2
    (st_r == tds_pkg::TDS_MEAS && i_sample_done && samp_left_r > 16'h1 && !ctl[1])
    |=> st_r == tds_pkg::TDS_DELAY && cnt_r == $past(active_dly))
    else $error("delay not reloaded before next reading");
  dly_min_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R3
    ctl[`TDS_CTRL_DLYMIN] |=> delay_r == 32'h0 && explicit_r)
    else $error("minimum delay not loaded");
  dly_max_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R3
    (ctl[`TDS_CTRL_DLYMAX] && !ctl[`TDS_CTRL_DLYMIN])
    |=> delay_r == `TDS_DLY_MAX_US && explicit_r) else $error("maximum delay not loaded");
  ohm_default_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R8
    (!explicit_r && cfg_r.func == tds_pkg::TDS_OHM4 && cfg_r.range == `TDS_RNG_1MOHM
     && !cfg_r.nplc_ge1) |-> active_dly == `TDS_DLY_10MS)
    else $error("wrong ohms default delay");
  ac_default_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R9
    (!explicit_r && cfg_r.func == tds_pkg::TDS_ACI && cfg_r.filter == 2'h1)
    |-> active_dly == `TDS_DLY_1S) else $error("wrong ac default delay");
  samp_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R12
    samp_r >= `TDS_CNT_MIN && samp_r <= `TDS_CNT_MAX)
    else $error("sample count out of range");
  trig_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R16
    trigs_r >= `TDS_CNT_MIN && trigs_r <= `TDS_CNT_MAX)
    else $error("trigger count out of range");
  start_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R2
    o_sample_start |-> st_r == tds_pkg::TDS_MEAS ##1 !o_sample_start)
    else $error("reading start not a single pulse");
  dc_default_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R7
    (!explicit_r && cfg_r.func == tds_pkg::TDS_DCV && cfg_r.nplc_ge1)
    |-> active_dly == `TDS_DLY_1MS5) else $error("wrong dc default delay");
  freq_default_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R10
    (!explicit_r && cfg_r.func == tds_pkg::TDS_FREQ) |-> active_dly == `TDS_DLY_1S)
    else $error("wrong frequency default delay");
  samp_max_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R13
    ctl[`TDS_CTRL_SMPMAX] && !ctl[`TDS_CTRL_SMPMIN] |=> samp_r == `TDS_CNT_MAX)
    else $error("maximum sample count not loaded");
  final_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R15
    (st_r == tds_pkg::TDS_MEAS && i_sample_done && samp_left_r == 16'h1
     && trig_left_r == 16'h1) |=> st_r == tds_pkg::TDS_IDLE)
    else $error("no return to idle after last reading");
  idle_ignore_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R17
    st_r == tds_pkg::TDS_IDLE |=> st_r != tds_pkg::TDS_DELAY)
    else $error("trigger acted on in idle");
  setup_ignore_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R18
    st_r == tds_pkg::TDS_SETUP |=> st_r != tds_pkg::TDS_DELAY)
    else $error("trigger acted on during setup");
  ext_edge_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R19
    (st_r == tds_pkg::TDS_WAIT && cfg_r.src == tds_pkg::TDS_SRC_EXT && !ctl[1]
     && ext_prev_r && !i_ext_trig_n) |=> st_r == tds_pkg::TDS_DELAY)
    else $error("external falling edge missed");
  tick_rate_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // R20
    (st_r == tds_pkg::TDS_DELAY && cnt_r != 32'h0 && tick && !ctl[1])
    |=> cnt_r == $past(cnt_r) - 32'h1) else $error("delay did not count a tick");

endmodule : tds_sequencer

// [src/tds_cfg.svh]
`ifndef TDS_CFG_SVH
`define TDS_CFG_SVH
`define TDS_CLK_HZ        10000000
`define TDS_TICK_US       1
`define TDS_TICK_CYC      ((`TDS_CLK_HZ / 1000000) * `TDS_TICK_US)
`define TDS_SETUP_MS      20
`define TDS_SETUP_CYC     ((`TDS_CLK_HZ / 1000) * `TDS_SETUP_MS)
`define TDS_OFF_CTRL      6'h00
`define TDS_OFF_STATUS    6'h04
`define TDS_OFF_DELAY     6'h08
`define TDS_OFF_SAMPLES   6'h0c
`define TDS_OFF_TRIGS     6'h10
`define TDS_OFF_MEASCFG   6'h14
`define TDS_OFF_DLY_MIN   6'h18
`define TDS_OFF_DLY_MAX   6'h1c
`define TDS_OFF_CNT_MIN   6'h20
`define TDS_OFF_CNT_MAX   6'h24
`define TDS_CTRL_INIT     0
`define TDS_CTRL_ABORT    1
`define TDS_CTRL_BUSTRG   2
`define TDS_CTRL_DFLT     3
`define TDS_CTRL_DLYMIN   4
`define TDS_CTRL_DLYMAX   5
`define TDS_CTRL_SMPMIN   6
`define TDS_CTRL_SMPMAX   7
`define TDS_CTRL_TRGMIN   8
`define TDS_CTRL_TRGMAX   9
`define TDS_DLY_MAX_US    32'hd693a400
`define TDS_DLY_QMIN_US   32'h00000001
`define TDS_CNT_MIN       16'h0001
`define TDS_CNT_MAX       16'hc350
`define TDS_DLY_1MS5      32'h000005dc
`define TDS_DLY_1MS       32'h000003e8
`define TDS_DLY_10MS      32'h00002710
`define TDS_DLY_100MS     32'h000186a0
`define TDS_DLY_600MS     32'h000927c0
`define TDS_DLY_1S        32'h000f4240
`define TDS_DLY_7S        32'h006acfc0
`define TDS_RNG_1MOHM     3'h4
`endif

// [src/tds_pkg.sv]
package tds_pkg;
  typedef enum logic [2:0] {TDS_DCV, TDS_DCI, TDS_OHM2, TDS_OHM4,
                            TDS_ACV, TDS_ACI, TDS_FREQ, TDS_PER} tds_func_e;
  typedef enum logic [1:0] {TDS_SRC_BUS, TDS_SRC_TTL, TDS_SRC_EXT, TDS_SRC_IMM} tds_src_e;
  typedef enum logic [2:0] {TDS_IDLE, TDS_SETUP, TDS_WAIT, TDS_DELAY, TDS_MEAS} tds_state_e;
  typedef struct packed {
    logic [2:0] ttl_sel;
    tds_src_e   src;
    logic [1:0] filter;
    logic       nplc_ge1;
    logic [2:0] range;
    tds_func_e  func;
  } tds_meas_cfg_s;
endpackage : tds_pkg

// [bench/tds_meas_model.sv]
`timescale 1ns/1ps
// Measurement side: answers each reading request i_lat + 1 cycles after it is sampled.
module tds_meas_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_start,
  input  wire logic [7:0] i_lat,
  output logic            o_done,
  output int              o_count
);
  logic [7:0] left_r;
  logic       run_r;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_r   <= 1'b0;
      left_r  <= 8'h00;
      o_done  <= 1'b0;
      o_count <= 0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        run_r   <= 1'b1;
        left_r  <= i_lat;
        o_count <= o_count + 1;
      end else if (run_r && left_r == 8'h00) begin
        run_r  <= 1'b0;
        o_done <= 1'b1;
      end else if (run_r) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
endmodule : tds_meas_model

// [bench/trigger_delay_sample_sequencer_tb.sv]
`timescale 1ns/1ps
`include "tds_cfg.svh"
module trigger_delay_sample_sequencer_tb;
  logic        clk, rst_n, rd, wr, ext_n, waitreq, start, busy, done;
  logic [5:0]  adr;
  logic [31:0] wd, rdata;
  logic [7:0]  ttl_n, lat;
  int          cnt, fail_count, n_checks;
  logic [31:0] cfg_t [13] = '{32'h000, 32'h041, 32'h042, 32'h01b, 32'h062, 32'h023, 32'h02a,
                              32'h073, 32'h004, 32'h085, 32'h104, 32'h006, 32'h007};
  logic [31:0] dly_t [13] = '{`TDS_DLY_1MS, `TDS_DLY_1MS5, `TDS_DLY_1MS5, `TDS_DLY_1MS,
                              `TDS_DLY_1MS5, `TDS_DLY_10MS, `TDS_DLY_100MS, `TDS_DLY_100MS,
                              `TDS_DLY_7S, `TDS_DLY_1S, `TDS_DLY_600MS, `TDS_DLY_1S, `TDS_DLY_1S};
  logic [31:0] src_t [3]  = '{32'h000, 32'h400, 32'ha00};

  tds_sequencer #(.SETUP_CYC(20)) i_dut (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_ext_trig_n(ext_n), .i_ttl_trig_n(ttl_n),
    .i_sample_done(done), .o_sample_start(start), .o_busy(busy));
  tds_meas_model i_meas (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_start(start), .i_lat(lat),
    .o_done(done), .o_count(cnt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  task automatic tmo(input string what);
    fail_count++;
    $display("Error %s expected answer seen timeout", what);
    report_and_stop();
  endtask : tmo
  // Request is held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (k == 20) tmo("waitrequest");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wrt(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrt
  task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask : rdc
  task automatic fire(input int s);
    if (s == 0) wrt(`TDS_OFF_CTRL, 32'h4);
    else begin
      @(posedge clk);
      if (s == 1) ext_n <= 1'b0;
      else ttl_n <= 8'hfd;
      repeat (8) @(posedge clk);
      ext_n <= 1'b1;
      ttl_n <= 8'hff;
    end
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("samples", `TDS_OFF_SAMPLES, 32'h1);
    rdc("trigs", `TDS_OFF_TRIGS, 32'h1);
    rdc("meascfg", `TDS_OFF_MEASCFG, 32'h0);
    rdc("delay", `TDS_OFF_DELAY, `TDS_DLY_1MS);
    rdc("dly min", `TDS_OFF_DLY_MIN, `TDS_DLY_QMIN_US);
    rdc("dly max", `TDS_OFF_DLY_MAX, `TDS_DLY_MAX_US);
    rdc("cnt min", `TDS_OFF_CNT_MIN, {16'h0, `TDS_CNT_MIN});
    rdc("cnt max", `TDS_OFF_CNT_MAX, {16'h0, `TDS_CNT_MAX});
    rdc("unmapped", 6'h3c, 32'h0);
    rdc("status", `TDS_OFF_STATUS, 32'h0);
  endtask : t_reset
  task automatic t_defaults;
    for (int i = 0; i < 13; i++) begin
      wrt(`TDS_OFF_MEASCFG, cfg_t[i]);
      rdc("default delay", `TDS_OFF_DELAY, dly_t[i]);
    end
  endtask : t_defaults
  task automatic t_explicit;
    wrt(`TDS_OFF_DELAY, 32'h5);
    wrt(`TDS_OFF_MEASCFG, 32'h000);
    rdc("explicit delay", `TDS_OFF_DELAY, 32'h5);
    rdc("status explicit", `TDS_OFF_STATUS, 32'h8);
    wrt(`TDS_OFF_CTRL, 32'h8);
    rdc("back to default", `TDS_OFF_DELAY, `TDS_DLY_1MS);
    wrt(`TDS_OFF_CTRL, 32'h10);
    rdc("delay min", `TDS_OFF_DELAY, 32'h0);
    wrt(`TDS_OFF_CTRL, 32'h20);
    rdc("delay max", `TDS_OFF_DELAY, `TDS_DLY_MAX_US);
    wrt(`TDS_OFF_DELAY, 32'hffffffff);
    rdc("delay clamp", `TDS_OFF_DELAY, `TDS_DLY_MAX_US);
    wrt(`TDS_OFF_SAMPLES, 32'h0);
    rdc("samples low", `TDS_OFF_SAMPLES, 32'h1);
    wrt(`TDS_OFF_SAMPLES, 32'hea60);
    rdc("samples high", `TDS_OFF_SAMPLES, {16'h0, `TDS_CNT_MAX});
    wrt(`TDS_OFF_CTRL, 32'h40);
    rdc("samples min", `TDS_OFF_SAMPLES, 32'h1);
    wrt(`TDS_OFF_CTRL, 32'h80);
    rdc("samples max", `TDS_OFF_SAMPLES, {16'h0, `TDS_CNT_MAX});
    wrt(`TDS_OFF_CTRL, 32'h200);
    rdc("trigs max", `TDS_OFF_TRIGS, {16'h0, `TDS_CNT_MAX});
    wrt(`TDS_OFF_CTRL, 32'h100);
    rdc("trigs min", `TDS_OFF_TRIGS, 32'h1);
  endtask : t_explicit
  // Two triggers of two readings each with a 3 us delay before every reading.
  task automatic t_sequence;
    int k;
    int n;
    int gap;
    wrt(`TDS_OFF_DELAY, 32'h3);
    wrt(`TDS_OFF_SAMPLES, 32'h2);
    wrt(`TDS_OFF_TRIGS, 32'h2);
    wrt(`TDS_OFF_MEASCFG, 32'h600);
    lat <= 8'h6;
    wrt(`TDS_OFF_CTRL, 32'h1);
    n = 0;
    gap = 0;
    for (k = 0; k < 600; k++) begin
      @(posedge clk);
      if (start === 1'b1) begin
        n++;
        if (n > 1) chk("delay gap", 32'h1, 32'(gap >= 30 && gap <= 42));
      end
      if (done === 1'b1) gap = 0;
      else gap++;
      if (busy === 1'b0) break;
    end
    if (k == 600) tmo("busy");
    chk("readings", 32'h4, 32'(n));
    rdc("status idle", `TDS_OFF_STATUS, 32'h8);
  endtask : t_sequence
  // Bus, external and backplane triggers: ignored in idle and setup, taken in wait.
  task automatic t_gating;
    int base;
    int k;
    wrt(`TDS_OFF_CTRL, 32'h18);
    wrt(`TDS_OFF_SAMPLES, 32'h1);
    lat <= 8'h1;
    for (int s = 0; s < 3; s++) begin
      wrt(`TDS_OFF_MEASCFG, src_t[s]);
      base = cnt;
      fire(s);
      repeat (25) @(posedge clk);
      chk("idle trigger", 32'(base), 32'(cnt));
      wrt(`TDS_OFF_CTRL, 32'h1);
      fire(s);
      repeat (25) @(posedge clk);
      chk("setup trigger", 32'(base), 32'(cnt));
      chk("busy in wait", 32'h1, {31'h0, busy});
      fire(s);
      if (s > 0) chk("edge before release", 32'(base + 1), 32'(cnt));
      for (k = 0; k < 60 && busy !== 1'b0; k++) @(posedge clk);
      if (k == 60) tmo("trigger");
      chk("wait trigger", 32'(base + 1), 32'(cnt));
    end
  endtask : t_gating
  // Reset in mid-run drops an explicit delay and stops the sequencer.
  task automatic t_midreset;
    wrt(`TDS_OFF_DELAY, 32'h7);
    wrt(`TDS_OFF_CTRL, 32'h1);
    rdc("status setup", `TDS_OFF_STATUS, 32'h9);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc("delay after reset", `TDS_OFF_DELAY, `TDS_DLY_1MS);
    rdc("status after reset", `TDS_OFF_STATUS, 32'h0);
  endtask : t_midreset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h00;
    wd = 32'h0;
    ext_n = 1'b1;
    ttl_n = 8'hff;
    lat = 8'h1;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_defaults();
    t_explicit();
    t_sequence();
    t_gating();
    t_midreset();
    report_and_stop();
  end
endmodule : trigger_delay_sample_sequencer_tb
